// ==== logic/edge_divider.sv ====
// Programmable divider counting input ticks, one output pulse per
// ratio ticks. Assumes ticks arrive synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module edge_divider #(
  parameter int W = 24
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] ratio_i,
  output var  logic         pulse_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] reload;
  logic         pulse_d;

  // ==========================================================
  // Down counter, reloads ratio minus one, zero acts as one
  always_comb
  begin
    reload  = (ratio_i == '0) ? '0 : W'(ratio_i - 1'b1);
    cnt_d   = cnt_q;
    pulse_d = 1'b0;
    if (tick_i)
    begin
      if (cnt_q == '0)
      begin
        cnt_d   = reload;
        pulse_d = 1'b1;
      end
      else
      begin
        cnt_d = W'(cnt_q - 1'b1);
      end
    end
  end

  // Counter registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q   <= '0;
      pulse_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_q   <= cnt_d;
      pulse_o <= pulse_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_div_wrap: assert property (ce_i && tick_i && cnt_q == '0 |=> pulse_o)
    else $error("divider missed its wrap pulse");
  a_div_step: assert property (ce_i && tick_i && cnt_q != '0
                               |=> !pulse_o && cnt_q == $past(cnt_q) - 1'b1)
    else $error("divider did not count a tick");

endmodule : edge_divider

`default_nettype wire

// ==== logic/synth_core.sv ====
// Synthesizer digital core: byte-loaded configuration, reference and
// feedback divide registers behind an AHB-Lite slave, two dividers
// and detector output steering.
// Assumes one AHB-Lite master, single word transfers, and frequency
// pins asynchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

module synth_core (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output var  logic [31:0] hrdata_o,
  output var  logic        hreadyout_o,
  output var  logic        hresp_o,
  input  wire logic        ref_freq_input_i,
  input  wire logic        feedback_frequency_input_i,
  output var  logic        detector_polarity_o,
  output var  logic        single_ended_phase_output_o,
  output var  logic        phase_ref_o,
  output var  logic        phase_osc_o
);

  localparam int SW = synth_pkg::REF_W - synth_pkg::BYTE_W;
  localparam int BW = synth_pkg::BYTE_W;

  // Bus state
  logic                       addr_ok;
  logic                       dp_wr_q;
  logic                       dp_wr_d;
  logic [synth_pkg::ADDR_W-1:0] dp_addr_q;
  logic [synth_pkg::ADDR_W-1:0] dp_addr_d;
  logic [31:0]                rdata_d;
  logic [31:0]                status;
  logic [2:0]                 size_seen;

  // Register state
  logic [BW-1:0]              wbyte;
  logic                       wr_cfg;
  logic                       wr_ref;
  logic                       wr_fb;
  logic [7:0]                 cfg_q;
  logic [7:0]                 cfg_d;
  logic [SW-1:0]              ref_stage_q;
  logic [SW-1:0]              ref_stage_d;
  logic [1:0]                 ref_cnt_q;
  logic [1:0]                 ref_cnt_d;
  logic [synth_pkg::REF_W-1:0] ref_ratio_q;
  logic [synth_pkg::REF_W-1:0] ref_ratio_d;
  logic [synth_pkg::REF_W-1:0] ref_full;
  logic [BW-1:0]              fb_stage_q;
  logic [BW-1:0]              fb_stage_d;
  logic                       fb_cnt_q;
  logic                       fb_cnt_d;
  logic [synth_pkg::FB_W-1:0] fb_ratio_q;
  logic [synth_pkg::FB_W-1:0] fb_ratio_d;
  logic [synth_pkg::FB_W-1:0] fb_full;

  // Pin synchronisers and edges
  logic [1:0]                 sync1_q;
  logic [1:0]                 sync2_q;
  logic [1:0]                 prev_q;
  logic                       ref_rise;
  logic                       fb_rise;
  logic                       ref_pulse;
  logic                       fb_pulse;

  // Detector state
  synth_pkg::pd_state_e       pd_q;
  synth_pkg::pd_state_e       pd_d;
  logic                       polarity;
  logic                       single_en;
  logic                       single_d;
  logic                       pref_d;
  logic                       posc_d;

  // ==========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  always_comb
  begin
    addr_ok   = hsel_i && hready_i && htrans_i[synth_pkg::HTRANS_ACTIVE_BIT];
    dp_wr_d   = addr_ok && hwrite_i;
    dp_addr_d = addr_ok ? haddr_i[synth_pkg::ADDR_W-1:0] : dp_addr_q;
    size_seen = hsize_i;
    rdata_d   = 32'h00000000;
    if (addr_ok && !hwrite_i && haddr_i[synth_pkg::ADDR_W-1:0] == synth_pkg::OFF_STAT)
    begin
      rdata_d = status;
    end
  end

  // Bus registers
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dp_wr_q     <= 1'b0;
      dp_addr_q   <= '0;
      hrdata_o    <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      dp_wr_q     <= dp_wr_d;
      dp_addr_q   <= dp_addr_d;
      hrdata_o    <= rdata_d;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // Status word shows load progress and detector level
  always_comb
  begin
    status = 32'h00000000;
    status[synth_pkg::ST_REF_CNT_LSB +: 2] = ref_cnt_q;
    status[synth_pkg::ST_FB_CNT_BIT]       = fb_cnt_q;
    status[synth_pkg::ST_SINGLE_BIT]       = single_ended_phase_output_o;
  end

  // ==========================================================
  // Byte loaders, most significant byte first
  assign wbyte    = hwdata_i[BW-1:0];
  assign wr_cfg   = dp_wr_q && dp_addr_q == synth_pkg::OFF_CFG;
  assign wr_ref   = dp_wr_q && dp_addr_q == synth_pkg::OFF_REF;
  assign wr_fb    = dp_wr_q && dp_addr_q == synth_pkg::OFF_FB;
  assign ref_full = {ref_stage_q, wbyte};
  assign fb_full  = {fb_stage_q, wbyte};

  // Next register values; nothing changes without a write
  always_comb
  begin
    cfg_d       = cfg_q;
    ref_stage_d = ref_stage_q;
    ref_cnt_d   = ref_cnt_q;
    ref_ratio_d = ref_ratio_q;
    fb_stage_d  = fb_stage_q;
    fb_cnt_d    = fb_cnt_q;
    fb_ratio_d  = fb_ratio_q;
    if (wr_cfg)
    begin
      cfg_d = wbyte;
    end
    if (wr_ref)
    begin
      if (ref_cnt_q == synth_pkg::REF_LAST)
      begin
        ref_ratio_d = ref_full;
        ref_cnt_d   = 2'h0;
      end
      else
      begin
        ref_stage_d = {ref_stage_q[SW-BW-1:0], wbyte};
        ref_cnt_d   = 2'(ref_cnt_q + 1'b1);
      end
    end
    if (wr_fb)
    begin
      if (fb_cnt_q == synth_pkg::FB_LAST)
      begin
        fb_ratio_d = fb_full;
        fb_cnt_d   = 1'b0;
      end
      else
      begin
        fb_stage_d = wbyte;
        fb_cnt_d   = 1'b1;
      end
    end
  end

  // Register file
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_q       <= synth_pkg::CFG_RST;
      ref_stage_q <= '0;
      ref_cnt_q   <= 2'h0;
      ref_ratio_q <= synth_pkg::REF_RST;
      fb_stage_q  <= '0;
      fb_cnt_q    <= 1'b0;
      fb_ratio_q  <= synth_pkg::FB_RST;
    end
    else if (ce_i)
    begin
      cfg_q       <= cfg_d;
      ref_stage_q <= ref_stage_d;
      ref_cnt_q   <= ref_cnt_d;
      ref_ratio_q <= ref_ratio_d;
      fb_stage_q  <= fb_stage_d;
      fb_cnt_q    <= fb_cnt_d;
      fb_ratio_q  <= fb_ratio_d;
    end
  end

  // ==========================================================
  // Two-stage synchronisers, bit 0 reference, bit 1 feedback
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      prev_q  <= 2'h0;
    end
    else if (ce_i)
    begin
      sync1_q <= {feedback_frequency_input_i, ref_freq_input_i};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Every rising edge is a tick, glitches included
  assign ref_rise = sync2_q[0] && !prev_q[0];
  assign fb_rise  = sync2_q[1] && !prev_q[1];

  // ==========================================================
  // Reference and feedback dividers
  edge_divider #(
    .W (synth_pkg::REF_W)
  ) u_ref_div (
    .clk_i   (ref_clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .tick_i  (ref_rise),
    .ratio_i (ref_ratio_q),
    .pulse_o (ref_pulse)
  );

  edge_divider #(
    .W (synth_pkg::FB_W)
  ) u_fb_div (
    .clk_i   (ref_clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .tick_i  (fb_rise),
    .ratio_i (fb_ratio_q),
    .pulse_o (fb_pulse)
  );

  // ==========================================================
  // Detector steering: lead state and output selection
  always_comb
  begin
    polarity  = cfg_q[synth_pkg::CFG_POLARITY_BIT];
    single_en = cfg_q[synth_pkg::CFG_SINGLE_BIT];
    pd_d      = pd_q;
    case (pd_q)
      synth_pkg::PD_IDLE:
      begin
        if (ref_pulse && !fb_pulse)
          pd_d = synth_pkg::PD_REF_LEAD;
        else if (fb_pulse && !ref_pulse)
          pd_d = synth_pkg::PD_OSC_LEAD;
      end
      synth_pkg::PD_REF_LEAD:
      begin
        if (fb_pulse)
          pd_d = synth_pkg::PD_IDLE;
      end
      synth_pkg::PD_OSC_LEAD:
      begin
        if (ref_pulse)
          pd_d = synth_pkg::PD_IDLE;
      end
      default:
      begin
        pd_d = synth_pkg::PD_IDLE;
      end
    endcase
    // Single-ended output only when selected, inverted by polarity
    single_d = 1'b0;
    if (single_en)
    begin
      if (pd_q == synth_pkg::PD_REF_LEAD)
        single_d = !polarity;
      else if (pd_q == synth_pkg::PD_OSC_LEAD)
        single_d = polarity;
    end
    // Double-ended outputs only when single-ended is off
    pref_d = !single_en && (polarity ? fb_pulse : ref_pulse);
    posc_d = !single_en && (polarity ? ref_pulse : fb_pulse);
  end

  // Detector registers, all outputs straight from flops
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pd_q                        <= synth_pkg::PD_IDLE;
      detector_polarity_o         <= 1'b0;
      single_ended_phase_output_o <= 1'b0;
      phase_ref_o                 <= 1'b0;
      phase_osc_o                 <= 1'b0;
    end
    else if (ce_i)
    begin
      pd_q                        <= pd_d;
      detector_polarity_o         <= polarity;
      single_ended_phase_output_o <= single_d;
      phase_ref_o                 <= pref_d;
      phase_osc_o                 <= posc_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_ref_commit: assert property (ce_i && wr_ref && ref_cnt_q == synth_pkg::REF_LAST
                                 |=> ref_ratio_q == $past(ref_full))
    else $error("reference ratio not committed on last byte");
  a_ref_partial: assert property (ce_i && wr_ref && ref_cnt_q != synth_pkg::REF_LAST
                                  |=> $stable(ref_ratio_q) && ref_cnt_q != 2'h0)
    else $error("reference ratio changed on a partial load");
  a_fb_commit: assert property (ce_i && wr_fb && fb_cnt_q == synth_pkg::FB_LAST
                                |=> fb_ratio_q == $past(fb_full) && !fb_cnt_q)
    else $error("feedback ratio not taken on its second byte");
  a_hold_regs: assert property (!dp_wr_q |=> $stable(cfg_q) && $stable(ref_ratio_q)
                                && $stable(fb_ratio_q))
    else $error("register changed without a write");
  a_single_only: assert property (ce_i && cfg_q[synth_pkg::CFG_SINGLE_BIT]
                                  |=> !phase_ref_o && !phase_osc_o)
    else $error("double-ended output active in single-ended mode");
  a_double_only: assert property (ce_i && !cfg_q[synth_pkg::CFG_SINGLE_BIT]
                                  |=> !single_ended_phase_output_o)
    else $error("single-ended output active in double-ended mode");
  a_polarity_out: assert property (ce_i && wr_cfg ##1 ce_i
                                   |=> detector_polarity_o == $past(hwdata_i[7], 2))
    else $error("polarity output does not follow the written bit");
  a_status_read: assert property (ce_i && addr_ok && !hwrite_i
                                  && haddr_i[7:0] == synth_pkg::OFF_STAT
                                  |=> hrdata_o == $past(status) && hreadyout_o)
    else $error("status read returned wrong data");

  c_cfg_single: cover property (ce_i && wr_cfg && wbyte == 8'hc0);
  c_cfg_double: cover property (ce_i && wr_cfg && wbyte == 8'h80);
  c_ref_load: cover property (ce_i && wr_ref && ref_cnt_q == synth_pkg::REF_LAST);
  c_fb_pulse: cover property (fb_pulse ##[1:50] ref_pulse);

endmodule : synth_core

`default_nettype wire

// ==== logic/synth_pkg.sv ====
// Shared constants of the synthesizer divider core: register map,
// configuration fields, reset values and bus encodings.
// Assumes a single AHB-Lite master doing whole-word single transfers.
`default_nettype none

package synth_pkg;

  // ==========================================================
  // Register map (byte addresses, low address bits only)
  localparam int          ADDR_W   = 8;
  localparam logic [7:0]  OFF_CFG  = 8'h00;
  localparam logic [7:0]  OFF_REF  = 8'h04;
  localparam logic [7:0]  OFF_FB   = 8'h08;
  localparam logic [7:0]  OFF_STAT = 8'h0c;

  // ==========================================================
  // Widths and byte counts
  localparam int          BYTE_W   = 8;
  localparam int          REF_W    = 24;
  localparam int          FB_W     = 16;
  localparam logic [1:0]  REF_LAST = 2'h2;
  localparam logic        FB_LAST  = 1'b1;

  // ==========================================================
  // Configuration byte fields
  localparam int          CFG_POLARITY_BIT = 7;
  localparam int          CFG_SINGLE_BIT   = 6;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [23:0] REF_RST  = 24'h000001;
  localparam logic [15:0] FB_RST   = 16'h0001;

  // ==========================================================
  // Status word fields
  localparam int          ST_REF_CNT_LSB = 0;
  localparam int          ST_FB_CNT_BIT  = 4;
  localparam int          ST_SINGLE_BIT  = 8;

  // ==========================================================
  // Bus encodings
  localparam int          HTRANS_ACTIVE_BIT = 1;

  // Single-ended detector state, Gray along idle-lead-idle
  typedef enum logic [1:0] {
    PD_IDLE     = 2'b00,
    PD_REF_LEAD = 2'b01,
    PD_OSC_LEAD = 2'b10
  } pd_state_e;

endpackage : synth_pkg

`default_nettype wire

// ==== testbench/host_model.sv ====
// Host controller model: an AHB-Lite master doing single word transfers.
// Assumes hready is the slave's hreadyout and one clock domain.
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic        ref_clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output var  logic        hsel_o,
  output var  logic [31:0] haddr_o,
  output var  logic [1:0]  htrans_o,
  output var  logic        hwrite_o,
  output var  logic [2:0]  hsize_o,
  output var  logic [31:0] hwdata_o
);
  // ==========================================================
  // Idle bus at time zero
  initial
  begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0;
  end

  // ==========================================================
  // One transfer: address phase held until hready, then data phase
  task automatic xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    @(posedge ref_clk_i);
    hsel_o   <= 1'b1;
    haddr_o  <= {24'h0, addr};
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    hsel_o   <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= wdata;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    rdata    = hrdata_i;
    // Released data lines show the inverse, never the stale value
    hwdata_o <= ~wdata;
  endtask : xfer

  // Each register is loaded as whole bytes, one byte per write
  task automatic put_byte(input logic [7:0] addr, input logic [7:0] b);
    logic [31:0] unused;
    xfer(addr, 1'b1, {24'h0, b}, unused);
  endtask : put_byte
endmodule : host_model

`default_nettype wire

// ==== testbench/synth_divider_programming_tb_top.sv ====
// Self-checking bench of the synthesizer divider core.
// Assumes the host model on the bus and pin ticks driven by the bench.
`timescale 1ns/1ps
`default_nettype none

module synth_divider_programming_tb_top;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        ref_pin   = 1'b0;
  logic        fb_pin    = 1'b0;
  logic        ce        = 1'b1;
  logic        hsel, hwrite, hready, hresp, detector_polarity, single, p_ref, p_osc;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          fails       = 0;
  int          total_checks = 0;
  int          cycles      = 0;
  int          ref_cnt     = 0;
  int          osc_cnt     = 0;

  // ==========================================================
  // Clock, pulse monitors and timeout
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    if (p_ref === 1'b1) ref_cnt <= ref_cnt + 1;
    if (p_osc === 1'b1) osc_cnt <= osc_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fails++;
      stop_test();
    end
  end

  host_model host (
    .ref_clk_i (ref_clk_i),
    .hready_i  (hready),
    .hrdata_i  (hrdata),
    .hsel_o    (hsel),
    .haddr_o   (haddr),
    .htrans_o  (htrans),
    .hwrite_o  (hwrite),
    .hsize_o   (hsize),
    .hwdata_o  (hwdata)
  );

  synth_core uut (
    .ref_clk_i                   (ref_clk_i),
    .rstn_i                      (rstn_i),
    .ce_i                        (ce),
    .hsel_i                      (hsel),
    .haddr_i                     (haddr),
    .htrans_i                    (htrans),
    .hwrite_i                    (hwrite),
    .hsize_i                     (hsize),
    .hwdata_i                    (hwdata),
    .hready_i                    (hready),
    .hrdata_o                    (hrdata),
    .hreadyout_o                 (hready),
    .hresp_o                     (hresp),
    .ref_freq_input_i            (ref_pin),
    .feedback_frequency_input_i  (fb_pin),
    .detector_polarity_o         (detector_polarity),
    .single_ended_phase_output_o (single),
    .phase_ref_o                 (p_ref),
    .phase_osc_o                 (p_osc)
  );

  // ==========================================================
  // Helpers
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string name);
    logic [31:0] d;
    host.xfer(addr, 1'b0, 32'h0, d);
    check(name, exp, d);
  endtask : rd_chk

  // Pin ticks of w clocks high and w clocks low
  task automatic ticks(input bit fb, input int n, input int w);
    repeat (n)
    begin
      if (fb) fb_pin <= 1'b1; else ref_pin <= 1'b1;
      repeat (w) @(posedge ref_clk_i);
      if (fb) fb_pin <= 1'b0; else ref_pin <= 1'b0;
      repeat (w) @(posedge ref_clk_i);
    end
    repeat (8) @(posedge ref_clk_i);
  endtask : ticks

  // Count detector pulses over n ticks after flushing the old ratio
  task automatic count(input bit fb, input int flush, input int n, input int w,
                       input int exp_ref, input int exp_osc);
    int r0;
    int o0;
    ticks(fb, flush, 2);
    r0 = ref_cnt;
    o0 = osc_cnt;
    ticks(fb, n, w);
    check("ref pulses", exp_ref, ref_cnt - r0);
    check("osc pulses", exp_osc, osc_cnt - o0);
  endtask : count

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(synth_pkg::OFF_STAT, 32'h0, "status at reset");
    rd_chk(synth_pkg::OFF_CFG, 32'h0, "config read back");
    rd_chk(8'h10, 32'h0, "unmapped read");
    check("hresp", 32'h0, {31'h0, hresp});
    check("hready", 32'h1, {31'h0, hready});
    check("polarity at reset", 32'h0, {31'h0, detector_polarity});
  endtask : t_reset

  task automatic t_ref();
    host.put_byte(synth_pkg::OFF_REF, 8'h00);
    rd_chk(synth_pkg::OFF_STAT, 32'h1, "ref count 1");
    host.put_byte(synth_pkg::OFF_REF, 8'h00);
    rd_chk(synth_pkg::OFF_STAT, 32'h2, "ref count 2");
    count(1'b0, 1, 20, 2, 20, 0);
    host.put_byte(synth_pkg::OFF_REF, 8'h14);
    rd_chk(synth_pkg::OFF_STAT, 32'h0, "ref count done");
    host.put_byte(synth_pkg::OFF_CFG, 8'h00);
    count(1'b0, 20, 40, 2, 2, 0);
  endtask : t_ref

  task automatic t_fb();
    host.put_byte(synth_pkg::OFF_FB, 8'h00);
    host.put_byte(synth_pkg::OFF_FB, 8'h04);
    count(1'b1, 1, 12, 1, 0, 3);
  endtask : t_fb

  // Clock enable low: feedback ticks must not move the divider
  task automatic t_freeze();
    ce <= 1'b0;
    count(1'b1, 0, 6, 2, 0, 0);
    ce <= 1'b1;
  endtask : t_freeze

  task automatic t_cfg();
    host.put_byte(synth_pkg::OFF_CFG, 8'h40);
    count(1'b0, 1, 20, 2, 0, 0);
    check("single 40", 32'h1, {31'h0, single});
    host.put_byte(synth_pkg::OFF_CFG, 8'hc0);
    count(1'b1, 4, 12, 2, 0, 0);
    check("polarity c0", 32'h1, {31'h0, detector_polarity});
    check("single c0", 32'h1, {31'h0, single});
    rd_chk(synth_pkg::OFF_STAT, 32'h100, "status single");
    host.put_byte(synth_pkg::OFF_CFG, 8'h80);
    count(1'b1, 4, 8, 2, 2, 0);
    check("single 80", 32'h0, {31'h0, single});
    check("polarity 80", 32'h1, {31'h0, detector_polarity});
  endtask : t_cfg

  task automatic t_partial();
    host.put_byte(synth_pkg::OFF_CFG, 8'h00);
    host.put_byte(synth_pkg::OFF_FB, 8'h01);
    rd_chk(synth_pkg::OFF_STAT, 32'h10, "fb pending");
    count(1'b1, 4, 8, 2, 0, 2);
    host.put_byte(synth_pkg::OFF_FB, 8'h00);
    count(1'b1, 4, 256, 1, 0, 1);
    rd_chk(synth_pkg::OFF_STAT, 32'h0, "fb done");
  endtask : t_partial

  // ==========================================================
  // Verdict and end of run
  task automatic stop_test();
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_ref();
    t_fb();
    t_freeze();
    t_cfg();
    t_partial();
    stop_test();
  end
endmodule : synth_divider_programming_tb_top

`default_nettype wire
